/* include/dpc_pkg.sv */
// How it works
// - strap and enable inputs are sampled on each rising edge of the conversion clock input
// - strap at mid-level selects strobe mode: strobe on B pin, format from A pin
// - in strobe mode there is no output enable; both sample buses stay driven
// - strap low gives offset binary output and strobe mode off
// - strap high gives two's complement output and strobe mode off
// - in strobe mode, A pin low means offset binary, high means two's complement
// - outside strobe mode the A pin is the output enable of the A bus
// - outside strobe mode the B bus is driven while its pin is low, else high-Z
// - in strobe mode sample outputs change with the falling strobe edge
// - the strobe toggles at the conversion clock rate, one period per period
// - power-down input high selects power-down, low selects active mode; a set CTRL_PWRDN_BIT also forces power-down with the pin low
// - each channel delivers a 12-bit parallel word on its own bus
// - bit zero carries the least, bit eleven the most significant result bit
package dpc_pkg;

    localparam int SAMPLE_W = 12;
    localparam int FIFO_DEPTH = 8;
    localparam int LEVEL_W = 4;

    // synchroniser vector layout
    localparam int SYNC_W = 6;
    localparam int SB_CONV = 5;
    localparam int SB_STRAP_HI = 4;
    localparam int SB_STRAP_LO = 3;
    localparam int SB_PIN_A = 2;
    localparam int SB_PIN_B = 1;
    localparam int SB_PD = 0;

    // three-level strap coding; any other code reads as mid-level
    localparam logic [1:0] STRAP_LOW = 2'h0;
    localparam logic [1:0] STRAP_HIGH = 2'h3;

    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_COUNT = 8'h08;

    localparam int CTRL_W = 2;
    localparam int CTRL_PWRDN_BIT = 0;
    localparam int CTRL_HOLD_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;

    localparam int ST_MODE_LSB = 0;
    localparam int ST_FMT_BIT = 2;
    localparam int ST_PD_BIT = 3;
    localparam int ST_AOE_BIT = 4;
    localparam int ST_BOE_BIT = 5;
    localparam int ST_LEVEL_LSB = 8;

    localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
    localparam logic [SYNC_W-1:0] SYNC_RESET = 6'h00;

    typedef enum logic [1:0] {
        MODE_OFFSET,
        MODE_STROBE,
        MODE_TWOS
    } dpc_mode_type;

endpackage

/* src/dpc_top.sv */
// Design decisions made here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps

module dpc_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 8,
    parameter int LW = 4
) (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o,
    output logic [LW-1:0] level_o
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [LW-1:0] FULL = LW'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [LW-1:0] count_r;
    logic [LW-1:0] count_nxt;
    logic ready_r;
    logic push;
    logic pop;

    assign push = in_valid_i & ready_r;
    assign pop = out_valid_o & out_ready_i;
    assign out_valid_o = (count_r != '0);
    assign out_data_o = mem[rd_ptr_r];
    assign in_ready_o = ready_r;
    assign level_o = count_r;

    always_comb begin
        count_nxt = count_r;
        if (push && !pop) begin
            count_nxt = count_r + LW'(1);
        end else if (pop && !push) begin
            count_nxt = count_r - LW'(1);
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
            ready_r <= 1'b0;
        end else begin
            count_r <= count_nxt;
            // registered so the source sees a flop, not a comparator
            ready_r <= (count_nxt != FULL);
            if (push) begin
                wr_ptr_r <= AW'(wr_ptr_r + AW'(1));
            end
            if (pop) begin
                rd_ptr_r <= AW'(rd_ptr_r + AW'(1));
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data_i;
        end
    end
endmodule

module dpc_top (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic conv_clk_i,
    input wire logic [1:0] format_ready_mode_strap_i,
    input wire logic chan_a_enable_format_pin_i,
    input wire logic chan_b_enable_strobe_pin_i,
    output logic chan_b_enable_strobe_pin_o,
    output logic chan_b_enable_strobe_pin_oe_o,
    input wire logic power_down_input_i,
    output logic [dpc_pkg::SAMPLE_W-1:0] chan_a_sample_bits_o,
    output logic chan_a_sample_oe_o,
    output logic [dpc_pkg::SAMPLE_W-1:0] chan_b_sample_bits_o,
    output logic chan_b_sample_oe_o,
    output logic powered_down_o,
    input wire logic core_valid_i,
    output logic core_ready_o,
    input wire logic [dpc_pkg::SAMPLE_W-1:0] core_a_result_i,
    input wire logic [dpc_pkg::SAMPLE_W-1:0] core_b_result_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    import dpc_pkg::*;

    localparam int FIFO_W = 2 * SAMPLE_W;

    logic [SYNC_W-1:0] sync_in;
    logic [SYNC_W-1:0] sync1_r;
    logic [SYNC_W-1:0] sync2_r;
    logic [SYNC_W-1:0] sync3_r;
    logic [SYNC_W-1:0] filt_r;
    logic [SYNC_W-1:0] filt_nxt;
    logic conv_rise;
    logic conv_fall;
    logic [1:0] strap_lvl;
    dpc_mode_type mode_r;
    dpc_mode_type mode_nxt;
    logic fmt_twos_r;
    logic a_oe_r;
    logic b_oe_r;
    logic strobe_r;
    logic strobe_oe_r;
    logic pd_r;
    logic pd_now;
    logic [CTRL_W-1:0] ctrl_r;
    logic [31:0] count_r;
    logic [SAMPLE_W-1:0] a_bits_r;
    logic [SAMPLE_W-1:0] b_bits_r;
    logic fifo_out_valid;
    logic [FIFO_W-1:0] fifo_out_data;
    logic [LEVEL_W-1:0] fifo_level;
    logic drain;
    logic ack_r;
    logic [31:0] dat_r;
    logic [31:0] rd_data;
    logic wb_req;

    // pins arrive from outside mclk; three flops, a change counts when 2nd and 3rd agree
    assign sync_in = {conv_clk_i, format_ready_mode_strap_i, chan_a_enable_format_pin_i,
                      chan_b_enable_strobe_pin_i, power_down_input_i};

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sync1_r <= SYNC_RESET;
            sync2_r <= SYNC_RESET;
            sync3_r <= SYNC_RESET;
            filt_r <= SYNC_RESET;
        end else begin
            sync1_r <= sync_in;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            filt_r <= filt_nxt;
        end
    end

    assign filt_nxt = (sync2_r & sync3_r) | (filt_r & (sync2_r ^ sync3_r));
    assign conv_rise = filt_nxt[SB_CONV] & ~filt_r[SB_CONV];
    assign conv_fall = ~filt_nxt[SB_CONV] & filt_r[SB_CONV];
    assign strap_lvl = filt_r[SB_STRAP_HI:SB_STRAP_LO];

    always_comb begin
        if (strap_lvl == STRAP_LOW) begin
            mode_nxt = MODE_OFFSET;
        end else if (strap_lvl == STRAP_HIGH) begin
            mode_nxt = MODE_TWOS;
        end else begin
            mode_nxt = MODE_STROBE;
        end
    end

    // strap and enable pins take effect only at a conversion clock rising edge
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mode_r <= MODE_OFFSET;
            fmt_twos_r <= 1'b0;
            a_oe_r <= 1'b0;
            b_oe_r <= 1'b0;
            strobe_oe_r <= 1'b0;
        end else if (conv_rise) begin
            mode_r <= mode_nxt;
            strobe_oe_r <= (mode_nxt == MODE_STROBE);
            if (mode_nxt == MODE_STROBE) begin
                fmt_twos_r <= filt_r[SB_PIN_A];
                a_oe_r <= 1'b1;
                b_oe_r <= 1'b1;
            end else begin
                fmt_twos_r <= (mode_nxt == MODE_TWOS);
                a_oe_r <= ~filt_r[SB_PIN_A];
                b_oe_r <= ~filt_r[SB_PIN_B];
            end
        end
    end

    assign pd_now = filt_r[SB_PD] | ctrl_r[CTRL_PWRDN_BIT];

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pd_r <= 1'b0;
        end else begin
            pd_r <= pd_now;
        end
    end

    // strobe follows the conversion clock, so one strobe period per input period
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            strobe_r <= 1'b0;
        end else if (mode_r != MODE_STROBE || pd_r) begin
            strobe_r <= 1'b0;
        end else if (conv_rise && mode_nxt == MODE_STROBE) begin
            // no rise on the edge that leaves strobe mode, else a one-cycle runt
            strobe_r <= 1'b1;
        end else if (conv_fall) begin
            strobe_r <= 1'b0;
        end
    end

    // power-down or a software hold stalls the drain, the fifo fills and
    // core_ready_o falls, so no result is ever dropped
    // in strobe mode a word moves only with a real strobe fall, never on a low strobe
    assign drain = conv_fall & ~pd_r & ~ctrl_r[CTRL_HOLD_BIT]
                   & ((mode_r != MODE_STROBE) | strobe_r);

    dpc_fifo #(
        .WIDTH(FIFO_W),
        .DEPTH(FIFO_DEPTH),
        .LW(LEVEL_W)
    ) u_fifo (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .in_valid_i(core_valid_i),
        .in_ready_o(core_ready_o),
        .in_data_i({core_b_result_i, core_a_result_i}),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(drain),
        .out_data_o(fifo_out_data),
        .level_o(fifo_level)
    );

    // core delivers offset binary; two's complement only flips the msb
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            a_bits_r <= '0;
            b_bits_r <= '0;
            count_r <= COUNT_RESET;
        end else if (drain && fifo_out_valid) begin
            a_bits_r <= {fifo_out_data[SAMPLE_W-1] ^ fmt_twos_r,
                         fifo_out_data[SAMPLE_W-2:0]};
            b_bits_r <= {fifo_out_data[FIFO_W-1] ^ fmt_twos_r,
                         fifo_out_data[FIFO_W-2:SAMPLE_W]};
            count_r <= count_r + 32'h0000_0001;
        end
    end

    // classic wishbone slave, answers one cycle after the strobe
    assign wb_req = wb_cyc_i & wb_stb_i & ~ack_r;

    always_comb begin
        rd_data = 32'h0000_0000;
        if (wb_adr_i == ADDR_CTRL) begin
            rd_data[CTRL_W-1:0] = ctrl_r;
        end else if (wb_adr_i == ADDR_STATUS) begin
            rd_data[ST_MODE_LSB +: 2] = mode_r;
            rd_data[ST_FMT_BIT] = fmt_twos_r;
            rd_data[ST_PD_BIT] = pd_r;
            rd_data[ST_AOE_BIT] = a_oe_r;
            rd_data[ST_BOE_BIT] = b_oe_r;
            rd_data[ST_LEVEL_LSB +: LEVEL_W] = fifo_level;
        end else if (wb_adr_i == ADDR_COUNT) begin
            rd_data = count_r;
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else begin
            ack_r <= wb_req;
            if (wb_req && !wb_we_i) begin
                dat_r <= rd_data;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl_r <= CTRL_RESET;
        end else if (wb_cyc_i && wb_stb_i && ack_r && wb_we_i && wb_adr_i == ADDR_CTRL
                     && wb_sel_i[0]) begin
            // lands at the edge where the master sees ack, as classic cycles expect
            ctrl_r <= wb_dat_i[CTRL_W-1:0];
        end
    end

    assign chan_a_sample_bits_o = a_bits_r;
    assign chan_b_sample_bits_o = b_bits_r;
    assign chan_a_sample_oe_o = a_oe_r;
    assign chan_b_sample_oe_o = b_oe_r;
    assign chan_b_enable_strobe_pin_o = strobe_r;
    assign chan_b_enable_strobe_pin_oe_o = strobe_oe_r;
    assign powered_down_o = pd_r;
    assign wb_dat_o = dat_r;
    assign wb_ack_o = ack_r;
endmodule

/* verification/dpc_top_sva.sv */
`timescale 1ns/1ps
module dpc_checker (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic [1:0] format_ready_mode_strap_i,
    input wire logic chan_a_enable_format_pin_i,
    input wire logic chan_b_enable_strobe_pin_i,
    input wire logic chan_b_enable_strobe_pin_o,
    input wire logic chan_b_enable_strobe_pin_oe_o,
    input wire logic power_down_input_i,
    input wire logic [dpc_pkg::SAMPLE_W-1:0] chan_a_sample_bits_o,
    input wire logic chan_a_sample_oe_o,
    input wire logic chan_b_sample_oe_o,
    input wire logic powered_down_o,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    a_no_tristate: assert property (
        chan_b_enable_strobe_pin_oe_o |-> chan_a_sample_oe_o && chan_b_sample_oe_o)
        else $error("sample bus released in strobe mode");
    a_strobe_mid_strap: assert property (
        $rose(chan_b_enable_strobe_pin_oe_o) |-> format_ready_mode_strap_i inside {2'h1, 2'h2})
        else $error("strobe mode without mid-level strap");
    a_strobe_off_strap: assert property (
        $fell(chan_b_enable_strobe_pin_oe_o) |-> format_ready_mode_strap_i inside {2'h0, 2'h3})
        else $error("strobe mode left with mid-level strap");
    a_data_on_fall: assert property (
        chan_b_enable_strobe_pin_oe_o && $changed(chan_a_sample_bits_o)
        |-> $fell(chan_b_enable_strobe_pin_o))
        else $error("data moved away from strobe fall");
    a_strobe_high_width: assert property (disable iff (!resetn_i || powered_down_o)
        $rose(chan_b_enable_strobe_pin_o) |-> chan_b_enable_strobe_pin_o[*8] ##[1:8]
        !chan_b_enable_strobe_pin_o)
        else $error("strobe high time off conversion rate");
    a_pd_follows_pin: assert property (
        power_down_input_i[*8] |-> powered_down_o)
        else $error("power-down pin ignored");
    a_a_enable_low: assert property (
        $rose(chan_a_sample_oe_o) && !chan_b_enable_strobe_pin_oe_o
        |-> !chan_a_enable_format_pin_i)
        else $error("A bus driven with enable high");
    a_b_enable_low: assert property (
        $fell(chan_b_sample_oe_o) && !$past(chan_b_enable_strobe_pin_oe_o)
        |-> chan_b_enable_strobe_pin_i)
        else $error("B bus released with enable low");
    a_ack_next: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus ack late");
endmodule

bind dpc_top dpc_checker i_dpc_checker (.mclk_i, .resetn_i, .format_ready_mode_strap_i,
    .chan_a_enable_format_pin_i, .chan_b_enable_strobe_pin_i, .chan_b_enable_strobe_pin_o,
    .chan_b_enable_strobe_pin_oe_o, .power_down_input_i, .chan_a_sample_bits_o,
    .chan_a_sample_oe_o, .chan_b_sample_oe_o, .powered_down_o, .wb_cyc_i, .wb_stb_i, .wb_ack_o);

/* verification/dpc_capture.sv */
`timescale 1ns/1ps
module dpc_capture (
    input wire logic mclk_i,
    input wire logic strobe_i,
    input wire logic strobe_oe_i,
    input wire logic a_oe_i,
    input wire logic b_oe_i,
    input wire logic [11:0] a_i,
    input wire logic [11:0] b_i,
    output logic got_o,
    output logic [23:0] word_o
);
    logic strobe_d_r = 1'h0;
    logic [23:0] last_r = 24'h0;
    logic fall;
    assign fall = strobe_d_r && !strobe_i && strobe_oe_i && a_oe_i && b_oe_i;
    // take the word one cycle after the fall, so it has settled on the bus;
    // a fall with unchanged data is a held word, not a new result
    always_ff @(posedge mclk_i) begin
        strobe_d_r <= strobe_i;
        got_o <= fall && ({a_i, b_i} != last_r);
        word_o <= {a_i, b_i};
        if (fall) begin
            last_r <= {a_i, b_i};
        end
    end
endmodule

/* verification/dpc_top_test.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module dpc_top_test;
    import dpc_pkg::*;
    logic mclk = 1'h0, resetn = 1'h0, conv = 1'h0, pin_a = 1'h0, b_drv = 1'h1, pd = 1'h0;
    logic cv = 1'h0, cyc = 1'h0, stb = 1'h0, we = 1'h0, b_o, b_oe, a_oe, bo_e, pdo, rdy, ack, got;
    logic [1:0] strap = 2'h0;
    logic [11:0] ca = 12'h0, cb = 12'h0, a_bits, b_bits, av, ra;
    logic [7:0] adr = 8'h0;
    logic [31:0] wdat = 32'h0, rd, wb_dat;
    logic [23:0] word, e;
    logic [23:0] exp_q[$];
    int num_errors = 0, n_tests = 0, i;
    wire b_wire = b_oe ? b_o : b_drv;
    dpc_top i_dpc_top (.mclk_i(mclk), .resetn_i(resetn), .conv_clk_i(conv),
        .format_ready_mode_strap_i(strap), .chan_a_enable_format_pin_i(pin_a),
        .chan_b_enable_strobe_pin_i(b_wire), .chan_b_enable_strobe_pin_o(b_o),
        .chan_b_enable_strobe_pin_oe_o(b_oe), .power_down_input_i(pd),
        .chan_a_sample_bits_o(a_bits), .chan_a_sample_oe_o(a_oe), .chan_b_sample_bits_o(b_bits),
        .chan_b_sample_oe_o(bo_e), .powered_down_o(pdo), .core_valid_i(cv), .core_ready_o(rdy),
        .core_a_result_i(ca), .core_b_result_i(cb), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(wb_dat),
        .wb_ack_o(ack));
    dpc_capture i_dpc_capture (.mclk_i(mclk), .strobe_i(b_o), .strobe_oe_i(b_oe),
        .a_oe_i(a_oe), .b_oe_i(bo_e), .a_i(a_bits), .b_i(b_bits), .got_o(got), .word_o(word));
    initial forever #2.5 mclk = ~mclk;
    // conversion clock free-running, phase unrelated to mclk
    initial begin
        #1.3;
        forever #62.5 conv = ~conv;
    end
    function automatic logic [11:0] cvt(input logic [11:0] v, input logic f);
        return f ? {~v[11], v[10:0]} : v;
    endfunction
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic limit(input int n);
        if (n >= 2000) begin
            num_errors++;
            print_verdict();
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'h1; stb <= 1'h1; we <= w; adr <= a; wdat <= d;
        i = 0;
        do begin @(posedge mclk); i++; end while (ack !== 1'h1 && i < 2000);
        limit(i);
        rd = wb_dat;
        cyc <= 1'h0; stb <= 1'h0;
        @(posedge mclk);
    endtask
    task automatic push(input logic [11:0] a, input logic [11:0] b);
        cv <= 1'h1; ca <= a; cb <= b;
        i = 0;
        do begin @(negedge mclk); i++; end while (rdy !== 1'h1 && i < 2000);
        limit(i);
        @(posedge mclk);
        cv <= 1'h0;
        @(posedge mclk);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge conv);
        repeat (8) @(posedge mclk);
    endtask
    always @(posedge mclk) if (got === 1'h1) begin
        e = exp_q.size() ? exp_q.pop_front() : 24'hXXXXXX;
        `CHK("captured word", e, word)
    end
    initial begin
        void'($urandom(53));
        repeat (2) @(posedge mclk);
        resetn <= 1'h1;
        wb(1'h0, ADDR_CTRL, 32'h0);
        `CHK("ctrl reset", {30'h0, CTRL_RESET}, rd)
        wb(1'h0, 8'h10, 32'h0);
        `CHK("unmapped read", 32'h0, rd)
        $display("register test done");
        for (int f = 0; f < 2; f++) begin
            strap <= 2'h1;
            pin_a <= f[0];
            if (f == 0) pd <= 1'h1;
            else wb(1'h1, ADDR_CTRL, 32'h2);
            settle(3);
            for (int k = 0; k < FIFO_DEPTH; k++) begin
                ra = 12'($urandom);
                av = 12'($urandom);
                push(ra, av);
                exp_q.push_back({cvt(ra, f[0]), cvt(av, f[0])});
            end
            @(negedge mclk);
            `CHK("fifo full", 1'h0, rdy)
            `CHK("powered down", ~f[0], pdo)
            @(posedge mclk);
            wb(1'h0, ADDR_STATUS, 32'h0);
            `CHK("fifo level", 4'h8, rd[ST_LEVEL_LSB+:4])
            `CHK("strobe oe", 1'h1, b_oe)
            if (f == 0) pd <= 1'h0;
            else wb(1'h1, ADDR_CTRL, 32'h0);
            i = 0;
            while (exp_q.size() != 0 && i < 2000) begin @(posedge mclk); i++; end
            limit(i);
            $display("strobe mode test %0d done", f);
        end
        for (int s = 0; s < 2; s++) begin
            strap <= s ? 2'h3 : 2'h0;
            pin_a <= 1'h0;
            b_drv <= 1'h1;
            settle(2);
            `CHK("strobe oe off", 1'h0, b_oe)
            `CHK("a driven", 1'h1, a_oe)
            `CHK("b released", 1'h0, bo_e)
            push(12'h801, 12'h0);
            settle(2);
            `CHK("a word", cvt(12'h801, s[0]), a_bits)
            pin_a <= 1'h1;
            b_drv <= 1'h0;
            settle(2);
            `CHK("a released", 1'h0, a_oe)
            `CHK("b driven", 1'h1, bo_e)
            $display("strap test %0d done", s);
        end
        wb(1'h0, ADDR_COUNT, 32'h0);
        `CHK("words delivered", 32'h12, rd)
        print_verdict();
    end
endmodule
